// File: adcsq_consts.svh
// Timing and layout constants for the converter scan sequencer
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH
`define ADCSQ_CLK_MHZ 125
`define ADCSQ_SLOT_NS 125000
`define ADCSQ_SCAN_NS 1000000
`define ADCSQ_SLOT_CYC ((`ADCSQ_SLOT_NS * `ADCSQ_CLK_MHZ) / 1000)
`define ADCSQ_RES_BITS 10
`define ADCSQ_NCHAN 8
`define ADCSQ_SHARED_CH 3'h5
`define ADCSQ_LAST_CH 3'h7
`define ADCSQ_SAMPLE_CYC 16
`define ADCSQ_MID_CODE 10'h200
`endif

// File: adcsq_pkg.sv
// Types shared by the converter scan sequencer
package adcsq_pkg;
   typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_SAMPLE, ADCSQ_CONVERT, ADCSQ_WAIT} adcsq_state_t;
   typedef struct packed {
      logic [2:0] chan;
      logic offset_sel;
   } adcsq_sel_t;
   typedef struct packed {
      logic valid;
      logic [2:0] chan;
      logic offset;
      logic [9:0] code;
   } adcsq_result_t;
endpackage : adcsq_pkg

// File: adcsq_sar.sv
// Successive-approximation bit-search engine returning one code per start pulse
`timescale 1ns/100ps
`default_nettype none
`include "adcsq_consts.svh"
module adcsq_sar
   import adcsq_pkg::*;
#(
   parameter int WIDTH = `ADCSQ_RES_BITS
)(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_start,
   input wire logic i_comp_high,
   output logic [WIDTH-1:0] o_trial,
   output logic o_done,
   output logic [WIDTH-1:0] o_code
);
   if (WIDTH < 2 || WIDTH > 16)
   begin : g_bad_width
      $error("adcsq_sar: bad WIDTH");
   end
   logic [WIDTH-1:0] bitmask;
   logic busy;
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         busy <= 1'b0;
         bitmask <= '0;
         o_trial <= '0;
         o_done <= 1'b0;
         o_code <= '0;
      end
      else
      begin
         o_done <= 1'b0;
         if (i_start)
         begin
            busy <= 1'b1;
            bitmask <= {1'b1, {(WIDTH-1){1'b0}}};
            o_trial <= {1'b1, {(WIDTH-1){1'b0}}};
         end
         else if (busy)
         begin
            // Comparator high means the trial exceeded the input: drop the bit
            if (bitmask == {{(WIDTH-1){1'b0}}, 1'b1})
            begin
               busy <= 1'b0;
               o_done <= 1'b1;
               o_code <= i_comp_high ? (o_trial & ~bitmask) : o_trial;
            end
            else
            begin
               bitmask <= bitmask >> 1;
               o_trial <= (i_comp_high ? (o_trial & ~bitmask) : o_trial) | (bitmask >> 1);
            end
         end
      end
   end
endmodule : adcsq_sar
`default_nettype wire

// File: adcsq_seq.sv
// Timed eight-channel scan sequencer for a shared 10-bit converter
// Behaviour
// - One shared SAR converter with sample-and-hold produces a 10-bit result.
// - Channel 5 slot alternates with internal offset channel; offset used for correction.
// - Channels 0-4,6-7 refresh every 1 ms; channel 5 every 2 ms.
// - Free-running fixed schedule from the clock; no sampling jitter.
// - Sampling plus conversion of each channel completes within 125 us.
// - Each external-channel result is written to the result RAM; offset results are not; full set after a scan.
// - Interrupt output goes low after channel 7 conversion ends.
// - Reset returns the sequencer to its initial state while held.
`timescale 1ns/100ps
`default_nettype none
`include "adcsq_consts.svh"
module adcsq_seq
   import adcsq_pkg::*;
#(
   parameter int SLOT_CYC = `ADCSQ_SLOT_CYC,
   parameter int SAMPLE_CYC = `ADCSQ_SAMPLE_CYC
)(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_comp_high,
   input wire logic i_factory_test_pin,
   output logic [2:0] o_mux_chan,
   output logic o_mux_offset,
   output logic o_hold,
   output logic [`ADCSQ_RES_BITS-1:0] o_trial,
   output logic o_int_n,
   output adcsq_result_t o_result,
   output logic [`ADCSQ_RES_BITS-1:0] o_offset_code
);
   localparam int RW = `ADCSQ_RES_BITS;
   // The slot must leave room for sampling, the bit search and the result write
   if (SAMPLE_CYC < 1 || SLOT_CYC < SAMPLE_CYC + RW + 4)
   begin : g_bad_slot
      $error("adcsq_seq: slot too short for sample plus conversion");
   end

   adcsq_state_t state;
   adcsq_sel_t sel;
   logic [31:0] slot_cnt;
   logic offset_turn;
   logic sar_start;
   logic sar_done;
   logic [RW-1:0] sar_code;
   logic [RW-1:0] ram [`ADCSQ_NCHAN];
   logic prev_shared_sel;

   // Clamped subtraction, used for every external channel result
   function automatic logic [RW-1:0] correct(input logic [RW-1:0] raw,
                                             input logic [RW-1:0] offs);
      logic [RW:0] diff;
      diff = {1'b0, raw} - {1'b0, offs} + {1'b0, `ADCSQ_MID_CODE};
      // Underflow also sets the top bit, so it must be tested first
      if ({1'b0, raw} + {1'b0, `ADCSQ_MID_CODE} < {1'b0, offs})
         correct = '0;
      else if (diff[RW])
         correct = {RW{1'b1}};
      else
         correct = diff[RW-1:0];
   endfunction : correct

   adcsq_sar #(.WIDTH(RW)) u_sar (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_start(sar_start),
      .i_comp_high(i_comp_high),
      // No extra stage: the comparator must judge the trial the engine decides on
      .o_trial(o_trial),
      .o_done(sar_done),
      .o_code(sar_code)
   );

   // Slot timer never depends on conversion length, so sampling instants are fixed
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         slot_cnt <= '0;
      else if (slot_cnt == 32'(SLOT_CYC - 1))
         slot_cnt <= '0;
      else
         slot_cnt <= slot_cnt + 32'h1;
   end

   // Channel order and channel 5 sharing
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         sel <= '0;
         offset_turn <= 1'b0;
      end
      else if (slot_cnt == 32'(SLOT_CYC - 1))
      begin
         sel.chan <= sel.chan + 3'h1;
         if (sel.chan == `ADCSQ_LAST_CH)
            offset_turn <= ~offset_turn;
         if (sel.chan + 3'h1 == `ADCSQ_SHARED_CH)
            sel.offset_sel <= offset_turn;
         else
            sel.offset_sel <= 1'b0;
      end
   end

   // Sample then convert inside each slot
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         state <= ADCSQ_IDLE;
         sar_start <= 1'b0;
         o_hold <= 1'b0;
      end
      else
      begin
         sar_start <= 1'b0;
         unique case (state)
            ADCSQ_IDLE, ADCSQ_WAIT:
               if (slot_cnt == '0)
               begin
                  state <= ADCSQ_SAMPLE;
                  o_hold <= 1'b0;
               end
            ADCSQ_SAMPLE:
               if (slot_cnt == 32'(SAMPLE_CYC))
               begin
                  state <= ADCSQ_CONVERT;
                  o_hold <= 1'b1;
                  sar_start <= 1'b1;
               end
            ADCSQ_CONVERT:
               if (sar_done)
                  state <= ADCSQ_WAIT;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_mux_chan <= '0;
         o_mux_offset <= 1'b0;
      end
      else
      begin
         o_mux_chan <= sel.chan;
         o_mux_offset <= sel.offset_sel;
      end
   end

   // Result store and offset correction
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_result <= '0;
         o_offset_code <= `ADCSQ_MID_CODE;
      end
      else
      begin
         o_result.valid <= 1'b0;
         if (sar_done)
         begin
            o_result.valid <= 1'b1;
            o_result.chan <= sel.chan;
            o_result.offset <= sel.offset_sel;
            if (sel.offset_sel)
            begin
               o_offset_code <= sar_code;
               o_result.code <= sar_code;
            end
            else
            begin
               ram[sel.chan] <= correct(sar_code, o_offset_code);
               o_result.code <= correct(sar_code, o_offset_code);
            end
         end
      end
   end

   // Test pin is expected grounded; the sequencer never reads it
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         o_int_n <= 1'b1;
      else if (sar_done && sel.chan == `ADCSQ_LAST_CH)
         o_int_n <= 1'b0;
      else if (slot_cnt == '0 && sel.chan == 3'h0)
         o_int_n <= 1'b1;
   end

   a_int_after_last: assert property (@(posedge i_clk) disable iff (i_reset)
      sar_done && sel.chan == `ADCSQ_LAST_CH |=> !o_int_n)
      else $error("interrupt not low after last channel");
   a_int_release: assert property (@(posedge i_clk) disable iff (i_reset)
      slot_cnt == '0 && sel.chan == 3'h0 && !sar_done |=> o_int_n)
      else $error("interrupt not released at scan start");
   a_chan_order: assert property (@(posedge i_clk) disable iff (i_reset)
      slot_cnt == 32'(SLOT_CYC - 1) |=> sel.chan == $past(sel.chan) + 3'h1)
      else $error("channel order broken");
   a_slot_wrap: assert property (@(posedge i_clk) disable iff (i_reset)
      slot_cnt == 32'(SLOT_CYC - 1) |=> slot_cnt == '0)
      else $error("slot timer did not wrap");
   a_offset_only5: assert property (@(posedge i_clk) disable iff (i_reset)
      sel.offset_sel |-> sel.chan == `ADCSQ_SHARED_CH)
      else $error("offset channel outside shared slot");
   a_conv_bound: assert property (@(posedge i_clk) disable iff (i_reset)
      sar_start |-> ##[1:12] sar_done)
      else $error("conversion too slow");
   a_hold_convert: assert property (@(posedge i_clk) disable iff (i_reset)
      state == ADCSQ_CONVERT |-> o_hold)
      else $error("hold released during conversion");
   a_result_stored: assert property (@(posedge i_clk) disable iff (i_reset)
      sar_done && !sel.offset_sel |=> ram[$past(sel.chan)] == o_result.code)
      else $error("result not stored");
   a_reset_state: assert property (@(posedge i_clk)
      i_reset |=> state == ADCSQ_IDLE && slot_cnt == '0 && o_int_n)
      else $error("reset did not restore sequencer");
   // Remembers what the shared slot converted last time; first scan after reset is external
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         prev_shared_sel <= 1'b1;
      else if (sar_done && sel.chan == `ADCSQ_SHARED_CH)
         prev_shared_sel <= sel.offset_sel;
   end

   a_ch5_alternate: assert property (@(posedge i_clk) disable iff (i_reset)
      sar_done && sel.chan == `ADCSQ_SHARED_CH |-> sel.offset_sel != prev_shared_sel)
      else $error("shared slot not alternating");
endmodule : adcsq_seq
`default_nettype wire

// File: adcsq_far_model.sv
// Analog side of the converter: track-and-hold source plus comparator
`timescale 1ns/100ps
`default_nettype none
module adcsq_far_model
   import adcsq_pkg::*;
(
   input wire logic i_clk,
   input wire logic [2:0] i_mux_chan,
   input wire logic i_mux_offset,
   input wire logic i_hold,
   input wire logic [9:0] i_trial,
   input wire logic [7:0][9:0] i_levels,
   input wire logic [9:0] i_offset_level,
   output logic o_comp_high
);
   logic [9:0] held;
   // Tracks the selected source until hold rises, then freezes it
   always_ff @(posedge i_clk)
   begin
      if (!i_hold)
         held <= i_mux_offset ? i_offset_level : i_levels[i_mux_chan];
   end
   assign o_comp_high = (i_trial > held);
endmodule : adcsq_far_model
`default_nettype wire

// File: adc_scan_sequencer_test.sv
// Self-checking bench for the converter scan sequencer
`timescale 1ns/100ps
`default_nettype none
module adc_scan_sequencer_test;
   import adcsq_pkg::*;
   localparam int SLOT = 40;
   logic i_clk;
   logic i_reset;
   logic comp_high;
   logic [2:0] mux_chan;
   logic mux_offset;
   logic hold;
   logic int_n;
   logic [9:0] trial;
   logic [9:0] offset_code;
   adcsq_result_t result;
   adcsq_result_t e;
   logic [7:0][9:0] levels;
   logic [9:0] off_level;
   logic [31:0] rnd;
   adcsq_result_t exp_q[$];
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int last7 = -1;
   int pend7 = 0;

   adcsq_seq #(.SLOT_CYC(SLOT), .SAMPLE_CYC(4)) i_dut (.i_clk(i_clk), .i_reset(i_reset),
      .i_comp_high(comp_high), .i_factory_test_pin(1'b0), .o_mux_chan(mux_chan),
      .o_mux_offset(mux_offset), .o_hold(hold), .o_trial(trial), .o_int_n(int_n),
      .o_result(result), .o_offset_code(offset_code));
   adcsq_far_model i_far (.i_clk(i_clk), .i_mux_chan(mux_chan), .i_mux_offset(mux_offset),
      .i_hold(hold), .i_trial(trial), .i_levels(levels), .i_offset_level(off_level),
      .o_comp_high(comp_high));

   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next

   task automatic check(input string what, input logic [15:0] exp_v, input logic [15:0] got);
      cmp_count++;
      if (got !== exp_v)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp_v, got);
      end
   endtask : check

   task wrap_up;
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   // New analog levels, applied while reset is held so no conversion sees a change
   task automatic new_levels;
      for (int c = 0; c < 8; c++)
      begin
         rnd = lfsr_next(rnd);
         levels[c] <= rnd[9:0];
      end
      off_level <= 10'h1f0 + {5'h00, rnd[14:10]};
      @(posedge i_clk);
   endtask : new_levels

   // Expected external results; offset applies from the first offset slot onward
   task automatic push_scans(input int n);
      int v;
      logic [9:0] off;
      for (int s = 0; s < n; s++)
         for (int c = 0; c < 8; c++)
         begin
            off = (s > 1 || (s == 1 && c > 5)) ? off_level : 10'h200;
            if (c == 5 && s % 2 == 1)
               continue;
            v = int'(levels[c]) - int'(off) + 512;
            v = v < 0 ? 0 : (v > 1023 ? 1023 : v);
            exp_q.push_back(adcsq_result_t'{1'b1, 3'(c), 1'b0, 10'(v)});
         end
   endtask : push_scans

   task automatic reset_phase(input int scans);
      i_reset <= 1'b1;
      exp_q.delete();
      new_levels();
      repeat (3) @(posedge i_clk);
      check("int_n", 1, int_n);
      check("hold", 0, hold);
      check("mux_chan", 0, mux_chan);
      check("offset_code", 16'h200, offset_code);
      check("valid", 0, result.valid);
      push_scans(scans);
      i_reset <= 1'b0;
      for (int k = 0; k < scans * 8 * SLOT + 100 && exp_q.size() > 0; k++)
         @(posedge i_clk);
      check("results left", 0, 16'(exp_q.size()));
   endtask : reset_phase

   always @(posedge i_clk)
   begin
      cyc++;
      if (pend7 > 0)
      begin
         pend7 = pend7 - 1;
         if (pend7 == 0)
            check("int_n after ch7", 0, int_n);
      end
      if (i_reset)
         last7 = -1;
      else if (result.valid === 1'b1 && result.offset === 1'b0)
      begin
         if (exp_q.size() == 0)
            check("extra result", 0, 1);
         else
         begin
            e = exp_q.pop_front();
            check("result", 16'(e), 16'(result));
         end
         if (result.chan === 3'h0)
            check("int_n at ch0", 1, int_n);
         if (result.chan === 3'h7)
         begin
            pend7 = 2;
            if (last7 >= 0)
               check("scan period", 16'(8 * SLOT), 16'(cyc - last7));
            last7 = cyc;
         end
      end
   end

   initial
   begin
      i_reset = 1'b1;
      rnd = 32'hfb92;
      levels = '0;
      off_level = 10'h200;
      repeat (10) @(posedge i_clk);
      reset_phase(4);
      check("offset_code", 16'(off_level), 16'(offset_code));
      // Short gap: long enough for the interrupt check, before the next result appears
      repeat (4) @(posedge i_clk);
      reset_phase(2);
      repeat (4) @(posedge i_clk);
      wrap_up();
   end

   initial
   begin
      repeat (5000) @(posedge i_clk);
      num_errors++;
      wrap_up();
   end
endmodule : adc_scan_sequencer_test
`default_nettype wire
